// ===== include/spe_map.svh
// Constants for setpoint entry and alarm check
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH
`define SPE_W            17
`define SPE_M2           16:13
`define SPE_M1           12:9
`define SPE_M0           8:5
`define SPE_MANT         16:5
`define SPE_ENEG         4
`define SPE_EXP          3:0
`define SPE_MANT_ONE     12'h100
`define SPE_POS_HIGH     4'h0
`define SPE_POS_WARN     4'h1
`define SPE_POS_DEAD     4'h2
`define SPE_POS_FULL     4'h3
`define SPE_POS_OVER     4'h4
`define SPE_POS_CONV     4'h5
`define SPE_POS_NONE     4'h6
`define SPE_POS_LOW      4'h7
`define SPE_POS_CAL      4'h8
`define SPE_POS_UNDER    4'h9
`define SPE_DEF_HIGH     17'h02003
`define SPE_DEF_WARN     17'h02001
`define SPE_DEF_DEAD     17'h00000
`define SPE_DEF_FULL     17'h02004
`define SPE_DEF_OVER     17'h02004
`define SPE_DEF_CONV     17'h02012
`define SPE_DEF_LOW      17'h02011
`define SPE_DEF_CAL      17'h0C001
`define SPE_DEF_UNDER    17'h02011
`define SPE_EDIT_LAST    3'h4
`define SPE_BOOT_CYC     2'h3
`define SPE_CLK_MHZ      125
`define SPE_SEC_MS       1000
`define SPE_ERR_DELAY_MS 2000
`endif

// ===== include/spe_pkg.sv
// Types for setpoint entry and alarm check
package spe_pkg;
  typedef enum logic [2:0] {ST_BOOT, ST_INIT, ST_WAIT, ST_IDLE, ST_EDIT} spe_state_t;
  typedef enum logic [2:0] {D_VAL, D_EDIT, D_E7, D_E8, D_ZERO, D_COUNT} spe_disp_t;
endpackage : spe_pkg

// ===== core/spe_core.sv
// Setpoint entry, validation and alarm comparison
`timescale 1ns/1ps
`include "spe_map.svh"
// Behaviour
// - Selector positions map to the nine parameters
// - Unused position shows E0007, no entry
// - Selector plus enter, value, digit buttons
// - First enter shows value, leftmost digit flashing
// - Value is three digits, sign, exponent
// - Value button advances flashing digit
// - Digit button moves flash one right
// - Second enter stores value, effective now
// - Enter held at power-up reloads defaults
// - Invalid setpoint refused, previous value kept
// - High between warn/underrange and overrange
// - High alarm when dose above high
// - Warn alarm when dose above warn
// - Warn between low scale and high
// - Full scale 1.00 decade above low
// - Full equal low gives E0008; below rejected
// - Low scale 1.00 decade below full
// - Range alarm above overrange; overrange checks
// - Below underrange shows zero, range alarm
// - Underrange not above high and warn
// - Calibrate mode counts pulses over time
// - Alarm outputs follow measured, not edited value
// - Conversion constant stored for dose conversion
// - E0008 shown two seconds after commit
module spe_core import spe_pkg::*; #(
  parameter int ERR_CYC = `SPE_ERR_DELAY_MS * 1000 * `SPE_CLK_MHZ,
  parameter int SEC_CYC = `SPE_SEC_MS * 1000 * `SPE_CLK_MHZ
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        clk_en_in,
  input  wire logic [3:0]  sel_in,
  input  wire logic        enter_in,
  input  wire logic        value_in,
  input  wire logic        digit_in,
  input  wire logic        det_pulse_in,
  input  wire logic [16:0] dose_in,
  output spe_disp_t        disp_mode_out,
  output logic [16:0]      disp_val_out,
  output logic [2:0]       flash_pos_out,
  output logic [31:0]      cal_count_out,
  output logic             high_alarm_out,
  output logic             warn_alarm_out,
  output logic             range_alarm_out,
  output logic             nv_wr_out,
  output logic [3:0]       nv_idx_out,
  output logic [16:0]      nv_data_out,
  output logic [16:0]      full_scale_out,
  output logic [16:0]      low_scale_out,
  output logic [16:0]      dead_time_out,
  output logic [16:0]      conv_const_out
);
  function automatic logic [3:0] spe_nd(input logic [3:0] d);
    spe_nd = (d >= 4'h9) ? 4'h0 : 4'(d + 4'h1);
  endfunction : spe_nd

  function automatic logic [16:0] spe_inc(input logic [16:0] v, input logic [2:0] p);
    logic [16:0] r;
    r = v;
    case (p)
      3'h0: r[`SPE_M2] = spe_nd(v[`SPE_M2]);
      3'h1: r[`SPE_M1] = spe_nd(v[`SPE_M1]);
      3'h2: r[`SPE_M0] = spe_nd(v[`SPE_M0]);
      3'h3: r[`SPE_ENEG] = ~v[`SPE_ENEG];
      default: r[`SPE_EXP] = spe_nd(v[`SPE_EXP]);
    endcase
    spe_inc = r;
  endfunction : spe_inc

  function automatic logic [15:0] spe_key(input logic [16:0] v);
    logic [9:0] m;
    m = 10'(v[`SPE_M2]) * 10'd100 + 10'(v[`SPE_M1]) * 10'd10 + 10'(v[`SPE_M0]);
    spe_key = (m == 10'h0) ? 16'h0 : {1'b1, v[`SPE_ENEG] ? 5'(5'd9 - 5'(v[`SPE_EXP])) :
                                      5'(5'd9 + 5'(v[`SPE_EXP])), m};
  endfunction : spe_key

  function automatic logic [31:0] spe_secs(input logic [16:0] v);
    logic [39:0] r;
    r = 40'(v[`SPE_M2]) * 40'd100 + 40'(v[`SPE_M1]) * 40'd10 + 40'(v[`SPE_M0]);
    for (int i = 0; i < 9; i++) begin
      if (!v[`SPE_ENEG] && i < int'(v[`SPE_EXP])) r = 40'(r * 40'd10);
    end
    spe_secs = 32'(r / 40'd100);
  endfunction : spe_secs

  function automatic logic [16:0] spe_def(input logic [3:0] i);
    case (i)
      `SPE_POS_HIGH:  spe_def = `SPE_DEF_HIGH;
      `SPE_POS_WARN:  spe_def = `SPE_DEF_WARN;
      `SPE_POS_FULL:  spe_def = `SPE_DEF_FULL;
      `SPE_POS_OVER:  spe_def = `SPE_DEF_OVER;
      `SPE_POS_CONV:  spe_def = `SPE_DEF_CONV;
      `SPE_POS_LOW:   spe_def = `SPE_DEF_LOW;
      `SPE_POS_CAL:   spe_def = `SPE_DEF_CAL;
      `SPE_POS_UNDER: spe_def = `SPE_DEF_UNDER;
      default:        spe_def = `SPE_DEF_DEAD;
    endcase
  endfunction : spe_def

  logic [1:0]  rst_sync;
  logic [7:0]  pin_s1, pin_s2, pin_s3;
  spe_state_t  state;
  logic [1:0]  boot_cnt;
  logic [3:0]  init_idx, edit_idx;
  logic [16:0] edit_val;
  logic [2:0]  pos;
  logic [16:0] sp [0:9];
  logic [27:0] err_cnt, sec_cnt;
  logic        scale_err;
  logic [31:0] acc, elapsed;

  wire rst_n = rst_sync[1];
  // Inputs: selector, enter, value, digit, detector pulse
  wire [3:0] sel    = pin_s2[7:4];
  wire       ent_p  = pin_s2[3] & ~pin_s3[3];
  wire       val_p  = pin_s2[2] & ~pin_s3[2];
  wire       dig_p  = pin_s2[1] & ~pin_s3[1];
  wire       pul_p  = pin_s2[0] & ~pin_s3[0];
  wire       unused = (sel == `SPE_POS_NONE) || (sel > `SPE_POS_UNDER);
  wire [15:0] k_e  = spe_key(edit_val);
  wire [15:0] k_d  = spe_key(dose_in);
  wire [15:0] k_hi = spe_key(sp[0]);
  wire [15:0] k_wa = spe_key(sp[1]);
  wire [15:0] k_fs = spe_key(sp[3]);
  wire [15:0] k_ov = spe_key(sp[4]);
  wire [15:0] k_ls = spe_key(sp[7]);
  wire [15:0] k_ur = spe_key(sp[9]);
  wire mant1 = edit_val[`SPE_MANT] == `SPE_MANT_ONE;
  wire valid =
    (edit_idx == `SPE_POS_HIGH)  ? (k_e >= k_wa && k_e >= k_ur && k_e <= k_ov) :
    (edit_idx == `SPE_POS_WARN)  ? (k_e >= k_ls && k_e <= k_hi) :
    (edit_idx == `SPE_POS_FULL)  ? (mant1 && k_e >= k_ls) :
    (edit_idx == `SPE_POS_OVER)  ? (k_e >= k_hi && k_e >= k_wa) :
    (edit_idx == `SPE_POS_LOW)   ? (mant1 && k_e <= k_fs) :
    (edit_idx == `SPE_POS_UNDER) ? (k_e <= k_hi && k_e <= k_wa) : 1'b1;
  wire commit   = state == ST_EDIT && ent_p;
  wire scale_wr = commit && valid && (edit_idx == `SPE_POS_FULL || edit_idx == `SPE_POS_LOW);
  wire cal_on   = state == ST_IDLE && sel == `SPE_POS_CAL;
  wire sec_tick = sec_cnt == 28'(SEC_CYC - 1);
  wire [31:0] cal_secs = spe_secs(sp[8]);
  wire under = k_d < k_ur;
  wire next_high  = k_d > k_hi;
  wire next_warn  = k_d > k_wa;
  wire next_range = (k_d > k_ov) || under;
  wire spe_disp_t next_mode =
    (state == ST_EDIT) ? D_EDIT :
    (state != ST_IDLE) ? D_VAL :
    unused ? D_E7 :
    scale_err ? D_E8 :
    cal_on ? D_COUNT :
    under ? D_ZERO : D_VAL;
  wire [16:0] next_val = (next_mode == D_EDIT) ? edit_val :
                         (next_mode == D_VAL) ? dose_in : 17'h00000;

  assign full_scale_out = sp[3];
  assign low_scale_out  = sp[7];
  assign dead_time_out  = sp[2];
  assign conv_const_out = sp[5];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else if (clk_en_in) begin
      pin_s1 <= {sel_in, enter_in, value_in, digit_in, det_pulse_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Entry state machine
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_BOOT;
      boot_cnt <= 2'h0;
      init_idx <= 4'h0;
      edit_idx <= 4'h0;
      edit_val <= 17'h00000;
      pos <= 3'h0;
      nv_wr_out <= 1'b0;
      nv_idx_out <= 4'h0;
      nv_data_out <= 17'h00000;
      for (int i = 0; i < 10; i++) sp[i] <= spe_def(4'(i));
    end else if (clk_en_in) begin
      nv_wr_out <= 1'b0;
      unique case (state)
        ST_BOOT: begin
          boot_cnt <= 2'(boot_cnt + 2'h1);
          if (boot_cnt == `SPE_BOOT_CYC) state <= pin_s2[3] ? ST_INIT : ST_IDLE;
        end
        ST_INIT: begin
          sp[init_idx] <= spe_def(init_idx);
          nv_wr_out <= 1'b1;
          nv_idx_out <= init_idx;
          nv_data_out <= spe_def(init_idx);
          init_idx <= 4'(init_idx + 4'h1);
          if (init_idx == `SPE_POS_UNDER) state <= ST_WAIT;
        end
        ST_WAIT: if (ent_p) state <= ST_IDLE;
        ST_IDLE: if (ent_p && !unused) begin
          state <= ST_EDIT;
          edit_idx <= sel;
          edit_val <= sp[sel];
          pos <= 3'h0;
        end
        ST_EDIT: if (ent_p) begin
          state <= ST_IDLE;
          if (valid) begin
            sp[edit_idx] <= edit_val;
            nv_wr_out <= 1'b1;
            nv_idx_out <= edit_idx;
            nv_data_out <= edit_val;
          end
        end else if (val_p) edit_val <= spe_inc(edit_val, pos);
        else if (dig_p) pos <= (pos == `SPE_EDIT_LAST) ? 3'h0 : 3'(pos + 3'h1);
      endcase
    end
  end

  // Delayed analog scale check
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt <= 28'h0;
      scale_err <= 1'b0;
    end else if (clk_en_in) begin
      if (scale_wr) err_cnt <= 28'(ERR_CYC);
      else if (err_cnt != 28'h0) err_cnt <= 28'(err_cnt - 28'h1);
      if (err_cnt == 28'h1) scale_err <= k_fs == k_ls;
    end
  end

  // Scaler for calibrate mode
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 28'h0;
      acc <= 32'h0;
      elapsed <= 32'h0;
      cal_count_out <= 32'h0;
    end else if (clk_en_in) begin
      sec_cnt <= sec_tick ? 28'h0 : 28'(sec_cnt + 28'h1);
      if (!cal_on) begin
        acc <= 32'h0;
        elapsed <= 32'h0;
      end else if (sec_tick && 32'(elapsed + 32'h1) >= cal_secs) begin
        cal_count_out <= 32'(acc + 32'(pul_p));
        acc <= 32'h0;
        elapsed <= 32'h0;
      end else begin
        acc <= 32'(acc + 32'(pul_p));
        if (sec_tick) elapsed <= 32'(elapsed + 32'h1);
      end
    end
  end

  // Display and alarm outputs
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      disp_mode_out <= D_VAL;
      disp_val_out <= 17'h00000;
      flash_pos_out <= 3'h0;
      high_alarm_out <= 1'b0;
      warn_alarm_out <= 1'b0;
      range_alarm_out <= 1'b0;
    end else if (clk_en_in) begin
      disp_mode_out <= next_mode;
      disp_val_out <= next_val;
      flash_pos_out <= pos;
      high_alarm_out <= next_high;
      warn_alarm_out <= next_warn;
      range_alarm_out <= next_range;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  sel_map_a: assert property (clk_en_in && state == ST_IDLE && ent_p && !unused |=>
    state == ST_EDIT && edit_idx == $past(sel)) else $error("selector not mapped");
  noimp_disp_a: assert property (clk_en_in && state == ST_IDLE && unused |=> disp_mode_out == D_E7)
    else $error("unused position not flagged");
  noimp_entry_a: assert property (state == ST_IDLE && unused |=> state != ST_EDIT)
    else $error("entry at unused position");
  flash_start_a: assert property (clk_en_in && state == ST_IDLE && ent_p && !unused |=>
    pos == 3'h0 && edit_val == sp[edit_idx]) else $error("edit start wrong");
  digit_wrap_a: assert property (clk_en_in && state == ST_EDIT && !ent_p && val_p &&
    pos == 3'h0 && edit_val[16:13] == 4'h9 |=> edit_val[16:13] == 4'h0) else $error("digit wrap");
  sign_toggle_a: assert property (clk_en_in && state == ST_EDIT && !ent_p && val_p && pos == 3'h3
    |=> edit_val[4] != $past(edit_val[4])) else $error("sign toggle");
  pos_move_a: assert property (clk_en_in && state == ST_EDIT && !ent_p && !val_p && dig_p &&
    pos < 3'h4 |=> pos == $past(pos) + 3'h1) else $error("flash position");
  commit_gate_a: assert property (clk_en_in && commit |=> nv_wr_out == $past(valid))
    else $error("commit gating");
  high_alarm_a: assert property (clk_en_in && k_d > k_hi |=> high_alarm_out)
    else $error("high alarm missed");
  range_alarm_a: assert property (clk_en_in && under |=> range_alarm_out)
    else $error("underrange alarm missed");
  scale_timer_a: assert property (clk_en_in && scale_wr |=> err_cnt == 28'(ERR_CYC))
    else $error("scale check timer");
  c_commit: cover property (commit && valid);
  c_refuse: cover property (commit && !valid);
  c_noimp: cover property (state == ST_IDLE && unused && ent_p);
  c_cal: cover property (cal_on && sec_tick);
endmodule : spe_core

// ===== dv/spe_operator.sv
// Operator model turning the selector and pressing the buttons
`timescale 1ns/1ps
module spe_operator (
  input  wire logic       core_clk_in,
  output logic      [3:0] sel_out,
  output logic            enter_out,
  output logic            value_out,
  output logic            digit_out
);
  initial begin
    sel_out   = 4'h0;
    enter_out = 1'b0;
    value_out = 1'b0;
    digit_out = 1'b0;
  end
  // Turn selector, let it settle
  task automatic turn(input logic [3:0] pos);
    @(negedge core_clk_in);
    sel_out = pos;
    repeat (4) @(negedge core_clk_in);
  endtask : turn
  // Press kind 0 enter, 1 value, 2 digit; hold then release
  task automatic press(input int kind, input int times);
    for (int i = 0; i < times; i++) begin
      @(negedge core_clk_in);
      enter_out = (kind == 0);
      value_out = (kind == 1);
      digit_out = (kind == 2);
      repeat (4) @(negedge core_clk_in);
      enter_out = 1'b0;
      value_out = 1'b0;
      digit_out = 1'b0;
      repeat (4) @(negedge core_clk_in);
    end
  endtask : press
  // Enter level held across power-up
  task automatic hold_enter(input logic level);
    @(negedge core_clk_in);
    enter_out = level;
  endtask : hold_enter
endmodule : spe_operator

// ===== dv/setpoint_entry_and_alarm_check_tb.sv
// Self-checking bench for setpoint entry and alarm check
`timescale 1ns/1ps
`include "spe_map.svh"
module setpoint_entry_and_alarm_check_tb import spe_pkg::*; ;
  localparam logic [16:0] DOSE_TAB [7] = '{17'h02003, 17'h02203, 17'h02004, 17'h02024, 17'h02001, 17'h02011, 17'h02012};
  localparam logic [3:0]  ALRM_TAB [7] = '{4'h4, 4'hC, 4'hC, 4'hE, 4'h0, 4'h0, 4'h3};
  logic        clk, rst_b, pulse, pulse_on, clk_en;
  logic [16:0] dose;
  logic [3:0]  sel;
  logic        ent, val, dig;
  spe_disp_t   mode;
  logic [16:0] dval, nv_data, full, low, dead, conv;
  logic [2:0]  flash;
  logic [31:0] cal;
  logic        hi, wa, rg, nv_wr;
  logic [3:0]  nv_idx;
  logic [16:0] nv_log [16];
  int          n_errors, samples_checked, nv_cnt;

  spe_operator i_op (.core_clk_in(clk), .sel_out(sel), .enter_out(ent), .value_out(val), .digit_out(dig));
  spe_core #(.ERR_CYC(20), .SEC_CYC(10)) i_dut (
    .core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .sel_in(sel), .enter_in(ent), .value_in(val),
    .digit_in(dig), .det_pulse_in(pulse), .dose_in(dose), .disp_mode_out(mode), .disp_val_out(dval),
    .flash_pos_out(flash), .cal_count_out(cal), .high_alarm_out(hi), .warn_alarm_out(wa), .range_alarm_out(rg),
    .nv_wr_out(nv_wr), .nv_idx_out(nv_idx), .nv_data_out(nv_data), .full_scale_out(full), .low_scale_out(low),
    .dead_time_out(dead), .conv_const_out(conv));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nv_wr === 1'b1) begin
      nv_cnt++;
      nv_log[nv_idx] = nv_data;
    end
  end
  always @(negedge clk) begin
    if (pulse_on) begin
      pulse <= ~pulse;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic do_reset(input logic held);
    i_op.hold_enter(held);
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (30) @(negedge clk);
    i_op.hold_enter(1'b0);
    repeat (8) @(negedge clk);
  endtask : do_reset
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    int n;
    rst_b = 1'b0;
    dose = 17'h02000;
    pulse = 1'b0;
    pulse_on = 1'b0;
    clk_en = 1'b1;
    do_reset(1'b0);
    check(full, `SPE_DEF_FULL, "full default");
    check(conv, `SPE_DEF_CONV, "conv default");
    check(dead, `SPE_DEF_DEAD, "dead default");
    for (int i = 0; i < 7; i++) begin
      dose = DOSE_TAB[i];
      repeat (3) @(negedge clk);
      check({hi, wa, rg, mode == D_ZERO}, ALRM_TAB[i], "alarm levels");
    end
    clk_en = 1'b0;
    dose = 17'h02203;
    repeat (3) @(negedge clk);
    check(hi, 1'b0, "alarm frozen");
    clk_en = 1'b1;
    repeat (3) @(negedge clk);
    check(hi, 1'b1, "alarm after enable");
    dose = 17'h02000;
    i_op.turn(4'h6);
    n = nv_cnt;
    i_op.press(0, 1);
    i_op.press(1, 1);
    i_op.press(0, 1);
    check(mode, D_E7, "unused position");
    check(nv_cnt, n, "unused position write");
    i_op.turn(4'hB);
    i_op.press(0, 1);
    check(mode, D_E7, "unused upper position");
    check(nv_cnt, n, "unused upper write");
    i_op.turn(4'h1);
    i_op.press(0, 1);
    check(mode, D_EDIT, "edit shown");
    check(dval, `SPE_DEF_WARN, "edit value");
    check(flash, 3'h0, "leftmost flash");
    i_op.press(1, 1);
    check(dval, 17'h04001, "value step");
    i_op.press(0, 1);
    check(nv_cnt, n + 1, "warn write");
    check(nv_log[1], 17'h04001, "stored warn");
    dose = 17'h02A01;
    repeat (3) @(negedge clk);
    check(wa, 1'b0, "new warn limit");
    i_op.turn(4'h0);
    n = nv_cnt;
    i_op.press(0, 1);
    i_op.press(2, 3);
    check(flash, 3'h3, "digit move");
    i_op.press(1, 1);
    check(dval, 17'h02013, "sign toggle");
    i_op.press(2, 1);
    i_op.press(1, 1);
    check(dval, 17'h02014, "exponent step");
    i_op.press(2, 1);
    check(flash, 3'h0, "digit wrap");
    i_op.press(0, 1);
    check(nv_cnt, n, "high refused");
    dose = 17'h02002;
    repeat (3) @(negedge clk);
    check(hi, 1'b0, "old high kept");
    i_op.turn(4'h1);
    n = nv_cnt;
    i_op.press(0, 1);
    i_op.press(2, 4);
    i_op.press(1, 3);
    i_op.press(0, 1);
    check(nv_cnt, n, "warn above high");
    i_op.turn(4'h4);
    i_op.press(0, 1);
    i_op.press(2, 3);
    i_op.press(1, 1);
    i_op.press(0, 1);
    check(nv_cnt, n, "over below high");
    i_op.turn(4'h9);
    i_op.press(0, 1);
    i_op.press(2, 3);
    i_op.press(1, 1);
    i_op.press(2, 1);
    i_op.press(1, 1);
    i_op.press(0, 1);
    check(nv_cnt, n, "under above warn");
    i_op.turn(4'h5);
    i_op.press(0, 1);
    i_op.press(1, 9);
    i_op.press(0, 1);
    check(conv, 17'h00012, "nine wraps");
    i_op.turn(4'h3);
    n = nv_cnt;
    i_op.press(0, 1);
    i_op.press(1, 1);
    i_op.press(0, 1);
    check(full, `SPE_DEF_FULL, "full mantissa");
    check(nv_cnt, n, "full refused");
    i_op.turn(4'h8);
    pulse_on = 1'b1;
    repeat (1300) @(negedge clk);
    pulse_on = 1'b0;
    check(mode, D_COUNT, "scaler display");
    check(cal >= 299 && cal <= 301, 1'b1, "scaler count");
    i_op.turn(4'h7);
    i_op.press(0, 1);
    i_op.press(2, 3);
    i_op.press(1, 1);
    i_op.press(2, 1);
    i_op.press(1, 3);
    i_op.press(0, 1);
    check(low, 17'h02004, "low equal full");
    check(mode == D_E8, 1'b0, "error too early");
    repeat (30) @(negedge clk);
    check(mode, D_E8, "scale error");
    i_op.turn(4'h3);
    n = nv_cnt;
    i_op.press(0, 1);
    i_op.press(2, 3);
    i_op.press(1, 1);
    i_op.press(0, 1);
    check(full, 17'h02004, "full below low");
    check(nv_cnt, n, "full below low write");
    check(mode, D_E8, "error persists");
    i_op.turn(4'h7);
    n = nv_cnt;
    do_reset(1'b1);
    check(nv_cnt - n, 10, "default writes");
    check(nv_log[0], `SPE_DEF_HIGH, "high default");
    check(nv_log[1], `SPE_DEF_WARN, "warn default");
    check(nv_log[8], `SPE_DEF_CAL, "cal default");
    i_op.press(0, 2);
    check(mode, D_EDIT, "normal after reload");
    check(dval, `SPE_DEF_LOW, "low reloaded");
    conclude();
  end
endmodule : setpoint_entry_and_alarm_check_tb
